// >>> verilog/cfg_load_pkg.sv
// constants of the fast parallel configuration loader
// assumes a 100 MHz system clock; times are converted to cycles here
package cfg_load_pkg;

  // system clock period in ns
  localparam int CLK_PERIOD_NS = 10;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_LENGTH = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_LAST   = 8'h0c;
  localparam logic [7:0] OFS_COUNT  = 8'h10;

  // control register fields
  localparam int CTRL_WIDTH_LSB  = 0;
  localparam int CTRL_DECOMP_BIT = 2;
  localparam int CTRL_SECURE_BIT = 3;
  localparam int CTRL_USRCLK_BIT = 4;

  // status register fields
  localparam int STAT_USER_BIT  = 0;
  localparam int STAT_DONE_BIT  = 1;
  localparam int STAT_HOLD_BIT  = 2;
  localparam int STAT_ERR_BIT   = 3;
  localparam int STAT_STATE_LSB = 4;

  // reset values
  localparam logic [4:0]  CTRL_RESET   = 5'h02;
  localparam logic [31:0] LENGTH_RESET = 32'h0000_0010;

  // bus width encodings
  localparam logic [1:0] WIDTH_8  = 2'h0;
  localparam logic [1:0] WIDTH_16 = 2'h1;
  localparam logic [1:0] WIDTH_32 = 2'h2;

  // clock-to-data ratios
  localparam logic [3:0] RATIO_PLAIN  = 4'h1;
  localparam logic [3:0] RATIO_SECURE = 4'h4;
  localparam logic [3:0] RATIO_DECOMP = 4'h8;

  // timing figures as printed
  localparam int STATUS_LOW_MIN_US   = 268;
  localparam int INIT_OSC_MIN_US     = 175;
  localparam int USRCLK_WAIT_PERIODS = 4;
  localparam int USRCLK_INIT_EDGES   = 8576;

  // derived cycle counts, least times rounded up
  localparam int STATUS_LOW_MIN_CYC =
    (STATUS_LOW_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int INIT_OSC_MIN_CYC =
    (INIT_OSC_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // clock-to-data ratio from the stream options
  function automatic logic [3:0] ratio_of(input logic decomp, input logic secure);
    logic [3:0] r;
    r = RATIO_PLAIN;
    if (decomp) begin
      r = RATIO_DECOMP;
    end else if (secure) begin
      r = RATIO_SECURE;
    end
    return r;
  endfunction

endpackage

// >>> verilog/pin_sync.sv
// two-flop synchroniser with rising-edge detect
// assumes input is asynchronous to clk
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] d,
  output var  logic [WIDTH-1:0] q,
  output var  logic [WIDTH-1:0] rise
);

  logic [WIDTH-1:0] meta_q;  // first stage, read only by stage two
  logic [WIDTH-1:0] sync_q;  // second stage
  logic [WIDTH-1:0] prev_q;  // delayed copy for edge detect

  // three flops, no logic on the first
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      sync_q <= '0;
      prev_q <= '0;
    end else begin
      meta_q <= d;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign q    = sync_q;
  assign rise = sync_q & ~prev_q;

endmodule
`default_nettype wire

// >>> verilog/cycle_timer.sv
// down-counting interval timer, reload on demand
// assumes load is a clk-domain pulse
`timescale 1ns/1ns
`default_nettype none
module cycle_timer (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        load,
  input  wire logic [31:0] value,
  output var  logic        expired
);

  logic [31:0] cnt_q;  // remaining cycles
  logic [31:0] cnt_d;
  logic        exp_q;  // count has reached zero
  logic        exp_d;

  // next count
  always_comb begin
    cnt_d = cnt_q;
    if (load) begin
      cnt_d = value;
    end else if (cnt_q != 32'h0000_0000) begin
      cnt_d = cnt_q - 32'h0000_0001;
    end
    exp_d = (cnt_d == 32'h0000_0000);
  end

  // registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 32'h0000_0000;
      exp_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      exp_q <= exp_d;
    end
  end

  assign expired = exp_q;

endmodule
`default_nettype wire

// >>> verilog/fast_parallel_load.sv
// fast parallel configuration loader, device end, with ahb-lite registers
// assumes pins are asynchronous to hclk; config_clock well below hclk / 2
`timescale 1ns/1ns
`default_nettype none
// Contract
// - extra edges spent decoding; one word per ratio
// - status and done low within 600 ns
// - status held low 268 to 1506 us
// - status released within 1506 us of request high
// - words captured on config clock rising edge
// - 8-bit uses 7..0, 16-bit uses 15..0
// - internal oscillator init 175 to 437 us
// - user clock init: wait, then 8576 periods
module fast_parallel_load
#(
  parameter int STATUS_MIN_CYC = cfg_load_pkg::STATUS_LOW_MIN_CYC,
  parameter int INIT_OSC_CYC   = cfg_load_pkg::INIT_OSC_MIN_CYC,
  parameter int USRCLK_EDGES   = cfg_load_pkg::USRCLK_INIT_EDGES,
  parameter int CFG_CLK_MAX_NS = 80
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output var  logic        hreadyout,
  output var  logic [31:0] hrdata,
  output var  logic        hresp,
  input  wire logic        config_request_n,
  input  wire logic        config_clock,
  input  wire logic [31:0] config_data,
  input  wire logic        user_init_clock,
  input  wire logic        config_status_n_in,
  output var  logic        config_status_n_out,
  output var  logic        config_status_n_oe_n,
  output var  logic        config_done_flag,
  output var  logic        user_mode
);
  import cfg_load_pkg::*;

  // wait after done before the user clock counts, in hclk cycles
  localparam int USRCLK_WAIT_CYC = (USRCLK_WAIT_PERIODS * CFG_CLK_MAX_NS
                                    + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic        req_n_s;     // synced request
  logic        stat_in_s;   // synced external status level
  logic        cclk_rise;   // config clock rising edge
  logic        uclk_rise;   // user init clock rising edge
  logic [31:0] data_s;      // synced data bus
  logic [3:0]  ctl_rise;    // edges of the control pins
  logic [1:0]  clk_lvl;     // clock pin levels, only their edges are used
  pin_sync #(.WIDTH(4)) u_ctl_sync (
    .clk   (hclk),
    .rst_n (hresetn),
    .d     ({config_request_n, config_status_n_in, config_clock, user_init_clock}),
    .q     ({req_n_s, stat_in_s, clk_lvl}),
    .rise  (ctl_rise)
  );
  assign cclk_rise = ctl_rise[1];
  assign uclk_rise = ctl_rise[0];

  // data synced in step with the config clock
  pin_sync #(.WIDTH(32)) u_data_sync (
    .clk   (hclk),
    .rst_n (hresetn),
    .d     (config_data),
    .q     (data_s),
    .rise  ()
  );

  ////////////////////////////////////////////////////////////////////////////
  // load state machine
  typedef enum logic [2:0] {
    S_CLEAR,   // status held low, memory cleared
    S_LOAD,    // taking words
    S_TAIL,    // trailing edges after the last word
    S_WAIT,    // internal oscillator init, or pause before the user init clock counts
    S_INIT,    // initialisation
    S_USER     // user mode
  } state_t;

  state_t      state_q;     // current state
  state_t      state_d;
  logic [2:0]  phase_q;     // edge index within a ratio period
  logic [2:0]  phase_d;
  logic [31:0] words_q;     // words taken so far
  logic [31:0] words_d;
  logic [31:0] last_q;      // last word taken
  logic [31:0] last_d;
  logic [31:0] uclk_cnt_q;  // user clock edges in init
  logic [31:0] uclk_cnt_d;
  logic        err_q;       // status pulled low from outside
  logic        err_d;
  logic        boot_q;      // first cycle after reset, arms the timer
  logic [1:0]  own_hi_q;    // own release, delayed like the synchroniser
  logic        stat_out_q;  // status pin drive level
  logic        stat_oen_q;  // status pin enable, low drives
  logic        done_q;      // done pin
  logic        user_q;      // user mode
  logic        timer_load;  // restart interval timer
  logic [31:0] timer_val;   // interval to load
  logic        timer_exp;   // interval over
  // register bus fields steering the machine
  logic [4:0]  ctrl_q;      // width, decompress, secure, user clock
  logic [31:0] length_q;    // words per image
  logic        err_clr;     // software clears the error flag
  logic [3:0]  ratio;       // current clock-to-data ratio
  logic        last_edge;   // edge that closes a ratio period
  assign ratio     = ratio_of(ctrl_q[CTRL_DECOMP_BIT], ctrl_q[CTRL_SECURE_BIT]);
  assign last_edge = ({1'b0, phase_q} == ratio - 4'h1);

  // mask data to the selected bus width
  function automatic logic [31:0] lane_mask(input logic [1:0] w, input logic [31:0] d);
    logic [31:0] m;
    m = d;
    if (w == WIDTH_8) begin
      m = {24'h00_0000, d[7:0]};
    end else if (w == WIDTH_16) begin
      m = {16'h0000, d[15:0]};
    end
    return m;
  endfunction

  cycle_timer u_timer (
    .clk     (hclk),
    .rst_n   (hresetn),
    .load    (timer_load),
    .value   (timer_val),
    .expired (timer_exp)
  );
  // next state and datapath
  always_comb begin
    state_d    = state_q;
    phase_d    = phase_q;
    words_d    = words_q;
    last_d     = last_q;
    uclk_cnt_d = uclk_cnt_q;
    err_d      = err_q;
    timer_load = boot_q;
    timer_val  = STATUS_MIN_CYC;
    if (err_clr) begin
      err_d = 1'b0;
    end
    unique case (state_q)
      S_CLEAR: begin
        // status held low the least pulse, longer while request low
        phase_d = 3'h0;
        words_d = 32'h0000_0000;
        if (timer_exp && req_n_s) begin
          state_d = S_LOAD;
        end
      end
      S_LOAD: begin
        if (own_hi_q[1] && !stat_in_s) begin
          // outside agent pulled status low: restart
          err_d      = 1'b1;
          state_d    = S_CLEAR;
          timer_load = 1'b1;
        end else if (cclk_rise) begin
          phase_d = last_edge ? 3'h0 : phase_q + 3'h1;
          if (phase_q == 3'h0) begin
            // one word per ratio period
            last_d  = lane_mask(ctrl_q[1:0], data_s);
            words_d = words_q + 32'h0000_0001;
            if (words_d >= length_q) begin
              if (ratio == RATIO_PLAIN) begin
                state_d    = S_WAIT;
                timer_load = 1'b1;
                timer_val  = ctrl_q[CTRL_USRCLK_BIT] ? USRCLK_WAIT_CYC : INIT_OSC_CYC;
              end else begin
                state_d = S_TAIL;
              end
            end
          end
        end
      end
      S_TAIL: begin
        // decode finishes on the host's trailing edges
        if (cclk_rise) begin
          phase_d = last_edge ? 3'h0 : phase_q + 3'h1;
          if (last_edge) begin
            state_d    = S_WAIT;
            timer_load = 1'b1;
            timer_val  = ctrl_q[CTRL_USRCLK_BIT] ? USRCLK_WAIT_CYC : INIT_OSC_CYC;
          end
        end
      end
      S_WAIT: begin
        // done is high; internal oscillator or user clock wait
        uclk_cnt_d = 32'h0000_0000;
        if (timer_exp) begin
          state_d = ctrl_q[CTRL_USRCLK_BIT] ? S_INIT : S_USER;
        end
      end
      S_INIT: begin
        // count user clock periods before user mode
        if (uclk_rise) begin
          uclk_cnt_d = uclk_cnt_q + 32'h0000_0001;
          if (uclk_cnt_d >= USRCLK_EDGES) begin
            state_d = S_USER;
          end
        end
      end
      S_USER: state_d = S_USER;  // held until request low
    endcase
    // request low restarts from any state other than S_CLEAR
    if (!req_n_s && state_q != S_CLEAR) begin
      state_d    = S_CLEAR;
      timer_load = 1'b1;
      timer_val  = STATUS_MIN_CYC;
    end
  end

  // registers of the machine and its pins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q    <= S_CLEAR;
      phase_q    <= 3'h0;
      words_q    <= 32'h0000_0000;
      last_q     <= 32'h0000_0000;
      uclk_cnt_q <= 32'h0000_0000;
      err_q      <= 1'b0;
      stat_out_q <= 1'b0;
      stat_oen_q <= 1'b0;
      done_q     <= 1'b0;
      user_q     <= 1'b0;
      boot_q     <= 1'b1;
      own_hi_q   <= 2'h0;
    end else begin
      state_q    <= state_d;
      phase_q    <= phase_d;
      words_q    <= words_d;
      last_q     <= last_d;
      uclk_cnt_q <= uclk_cnt_d;
      err_q      <= err_d;
      stat_out_q <= 1'b0;
      stat_oen_q <= (state_d != S_CLEAR);
      done_q     <= (state_d == S_WAIT) || (state_d == S_INIT) || (state_d == S_USER);
      user_q     <= (state_d == S_USER);
      boot_q     <= 1'b0;
      own_hi_q   <= {own_hi_q[0], stat_oen_q};  // pin seen high two edges later
    end
  end

  assign config_status_n_out  = stat_out_q;
  assign config_status_n_oe_n = stat_oen_q;
  assign config_done_flag     = done_q;
  assign user_mode            = user_q;

  ////////////////////////////////////////////////////////////////////////////
  // ahb-lite slave, zero wait states
  logic        rdy_q;     // ready flop, never waits
  logic        resp_q;    // response flop, always okay
  logic        ap_wr_q;   // data phase of a write pending
  logic        ap_wr_d;
  logic [7:0]  ap_ofs_q;  // offset latched in address phase
  logic [7:0]  ap_ofs_d;
  logic [4:0]  ctrl_d;
  logic [31:0] length_d;
  logic [31:0] rdata_q;   // read data, loaded in the address phase
  logic [31:0] rdata_d;
  logic        take;      // address phase accepted

  assign take = hsel && hready && htrans[1];

  // read mux for an offset
  function automatic logic [31:0] rd_mux(input logic [7:0] ofs);
    logic [31:0] v;
    v = 32'h0000_0000;
    unique case (ofs)
      OFS_CTRL:   v = {27'h000_0000, ctrl_q};
      OFS_LENGTH: v = length_q;
      OFS_STATUS: v = {25'h000_0000, 3'(state_q), err_q, ~stat_oen_q, done_q, user_q};
      OFS_LAST:   v = last_q;
      OFS_COUNT:  v = words_q;
      default:    v = 32'h0000_0000;
    endcase
    return v;
  endfunction

  // bus next values
  always_comb begin
    ap_wr_d  = take && hwrite;
    ap_ofs_d = take ? haddr[7:0] : ap_ofs_q;
    rdata_d  = (take && !hwrite) ? rd_mux(haddr[7:0]) : rdata_q;
    ctrl_d   = ctrl_q;
    length_d = length_q;
    err_clr  = 1'b0;
    if (ap_wr_q) begin
      if (ap_ofs_q == OFS_CTRL) begin
        ctrl_d = hwdata[4:0];
      end else if (ap_ofs_q == OFS_LENGTH) begin
        length_d = hwdata;
      end else if (ap_ofs_q == OFS_STATUS) begin
        err_clr = hwdata[STAT_ERR_BIT];
      end
    end
  end

  // bus registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_wr_q  <= 1'b0;
      ap_ofs_q <= 8'h00;
      rdata_q  <= 32'h0000_0000;
      ctrl_q   <= CTRL_RESET;
      length_q <= LENGTH_RESET;
      rdy_q    <= 1'b1;
      resp_q   <= 1'b0;
    end else begin
      ap_wr_q  <= ap_wr_d;
      ap_ofs_q <= ap_ofs_d;
      rdata_q  <= rdata_d;
      ctrl_q   <= ctrl_d;
      length_q <= length_d;
      rdy_q    <= 1'b1;
      resp_q   <= 1'b0;
    end
  end

  assign hreadyout = rdy_q;
  assign hrdata    = rdata_q;
  assign hresp     = resp_q;

endmodule
`default_nettype wire

// >>> sim/fast_parallel_load_monitor.sv
// pin and bus checker for the fast parallel configuration loader
// assumes hclk at 100 MHz; bound to every loader instance below
`timescale 1ns/1ns
`default_nettype none
module fast_parallel_load_monitor #(
  parameter int STATUS_MIN_CYC = 50,
  parameter int INIT_OSC_CYC   = 40,
  parameter int USRCLK_EDGES   = 10
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic config_request_n,
  input wire logic user_init_clock,
  input wire logic config_status_n_oe_n,
  input wire logic config_done_flag,
  input wire logic user_mode
);
  logic [31:0] low_q;  // cycles status pulled low
  logic [31:0] rel_q;  // cycles pulled low with request high
  logic [31:0] done_q; // cycles done without user mode
  logic [31:0] uck_q;  // user clock rises since done
  logic        uc_q;   // last user clock level
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  //////////////////////////////////////////////////////////////////
  // helper counters
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      low_q  <= 32'h0;
      rel_q  <= 32'h0;
      done_q <= 32'h0;
      uck_q  <= 32'h0;
      uc_q   <= 1'b0;
    end else begin
      low_q  <= config_status_n_oe_n ? 32'h0 : low_q + 32'h1;
      rel_q  <= (config_status_n_oe_n || !config_request_n) ? 32'h0 : rel_q + 32'h1;
      done_q <= (config_done_flag && !user_mode) ? done_q + 32'h1 : 32'h0;
      uck_q  <= config_done_flag ? uck_q + 32'(user_init_clock & ~uc_q) : 32'h0;
      uc_q   <= user_init_clock;
    end
  end
  //////////////////////////////////////////////////////////////////
  property p_req_low;
    $fell(config_request_n) |-> ##[1:60] (!config_done_flag && !config_status_n_oe_n);
  endproperty
  a_req_low: assert property (p_req_low) else $error("request low not answered");
  property p_done_hold;
    config_done_flag && config_request_n |=> config_done_flag;
  endproperty
  a_done_hold: assert property (p_done_hold) else $error("done dropped early");
  property p_status_min;
    $rose(config_status_n_oe_n) |-> low_q >= STATUS_MIN_CYC - 1;
  endproperty
  a_status_min: assert property (p_status_min) else $error("status low too short");
  property p_status_rel;
    rel_q <= STATUS_MIN_CYC + 8;
  endproperty
  a_status_rel: assert property (p_status_rel) else $error("status not released");
  property p_init_min;
    $rose(user_mode) |-> done_q >= INIT_OSC_CYC - 1;
  endproperty
  a_init_min: assert property (p_init_min) else $error("user mode too early");
  property p_init_max;
    config_done_flag && !user_mode && uck_q == 32'h0 |-> done_q <= INIT_OSC_CYC + 8;
  endproperty
  a_init_max: assert property (p_init_max) else $error("user mode too late");
  property p_usr_edges;
    $rose(user_mode) && uck_q != 32'h0 |-> uck_q >= USRCLK_EDGES;
  endproperty
  a_usr_edges: assert property (p_usr_edges) else $error("too few user clocks");
  property p_user_done;
    user_mode && config_request_n |-> config_done_flag;
  endproperty
  a_user_done: assert property (p_user_done) else $error("user mode without done");
  property p_bus_ok;
    hreadyout && !hresp;
  endproperty
  a_bus_ok: assert property (p_bus_ok) else $error("bus wait or error");
  c_user: cover property ($rose(user_mode));
  c_done: cover property ($rose(config_done_flag));
  c_req: cover property ($fell(config_request_n));
endmodule
bind fast_parallel_load fast_parallel_load_monitor #(.STATUS_MIN_CYC(STATUS_MIN_CYC),
  .INIT_OSC_CYC(INIT_OSC_CYC), .USRCLK_EDGES(USRCLK_EDGES)) u_mon (.hclk(hclk),
  .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp),
  .config_request_n(config_request_n), .user_init_clock(user_init_clock),
  .config_status_n_oe_n(config_status_n_oe_n), .config_done_flag(config_done_flag),
  .user_mode(user_mode));
`default_nettype wire

// >>> sim/cfg_host_model.sv
// external host that loads the device over the parallel pins
// assumes hclk at 100 MHz; config clock made from hclk at 80 ns
`timescale 1ns/1ns
`default_nettype none
module cfg_host_model (
  input  wire logic        hclk,
  input  wire logic        status_wire,
  output var  logic        config_request_n,
  output var  logic        config_clock,
  output var  logic [31:0] config_data
);
  // idle pins, clock stands still low
  initial begin
    config_request_n = 1'b1;
    config_clock     = 1'b0;
    config_data      = 32'h0;
  end
  // request pulse, then wait for status to free
  task automatic start();
    config_request_n <= 1'b0;
    repeat (200) @(posedge hclk);
    config_request_n <= 1'b1;
    for (int n = 0; n < 5000; n++) begin
      if (status_wire === 1'b1) break;
      @(posedge hclk);
    end
    repeat (200) @(posedge hclk);
  endtask
  // one word held over a number of rising edges
  task automatic send(input logic [31:0] w, input int edges);
    config_data <= w;
    repeat (edges) begin
      repeat (4) @(posedge hclk);
      config_clock <= 1'b1;
      repeat (4) @(posedge hclk);
      config_clock <= 1'b0;
    end
  endtask
  // released lines show the inverse of the last word
  task automatic idle();
    config_data <= ~config_data;
  endtask
endmodule
`default_nettype wire

// >>> sim/fast_parallel_load_tb.sv
// bench for the fast parallel loader: bus tasks plus host model
// assumes short parameter values so each load takes under 1000 cycles
`timescale 1ns/1ns
`default_nettype none
module fast_parallel_load_tb;
  import cfg_load_pkg::*;
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b1, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, config_data, rd;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic        hreadyout, hresp, config_request_n, config_clock, oe_n, done, user, st_out;
  logic        user_init_clock = 1'b0, ext_hold_n = 1'b1, uclk_run = 1'b0;
  wire         status_w = (oe_n | st_out) & ext_hold_n; // pulled-up open-drain status wire
  int          fail_count = 0, checks_done = 0, cyc = 0;
  localparam logic [4:0] MODES [5] = '{5'h00, 5'h09, 5'h06, 5'h0e, 5'h02};
  localparam int RATIOS [5] = '{1, 4, 8, 8, 1};
  localparam logic [31:0] MASKS [5] = '{32'hff, 32'hffff, 32'hffff_ffff,
    32'hffff_ffff, 32'hffff_ffff};
  fast_parallel_load #(.STATUS_MIN_CYC(50), .INIT_OSC_CYC(40), .USRCLK_EDGES(10),
    .CFG_CLK_MAX_NS(80)) u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .config_request_n(config_request_n), .config_clock(config_clock),
    .config_data(config_data), .user_init_clock(user_init_clock),
    .config_status_n_in(status_w), .config_status_n_out(st_out),
    .config_status_n_oe_n(oe_n), .config_done_flag(done), .user_mode(user));
  cfg_host_model u_host (.hclk(hclk), .status_wire(status_w),
    .config_request_n(config_request_n), .config_clock(config_clock),
    .config_data(config_data));
  always #5 hclk = ~hclk;
  //////////////////////////////////////////////////////////////////
  // watchdog and free user clock of 80 ns
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (uclk_run && cyc[1:0] == 2'h3) user_init_clock <= ~user_init_clock;
    if (cyc == 20000) begin
      $display("Error at %0t: timeout", $time);
      fail_count++;
      summarize();
    end
  end
  task automatic summarize();
    $display("checks %0d, errors %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // one single ahb-lite transfer; read data lands in rd
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  task automatic wait_flag(input logic want_user);
    for (int n = 0; n < 3000; n++) begin
      if ((want_user ? user : done) === 1'b1) break;
      @(posedge hclk);
    end
  endtask
  // three-word load; tail edges held back to see done wait for them
  task automatic run(input logic [4:0] ctrl, input int r, input logic [31:0] mask);
    bus(1'b1, OFS_LENGTH, 32'h3);
    bus(1'b1, OFS_CTRL, {27'h0, ctrl});
    u_host.start();
    chk({31'h0, done}, 32'h0);
    for (int i = 0; i < 3; i++) u_host.send(32'h5a3c_7e10 + i, (i < 2) ? r : 1);
    repeat (40) @(posedge hclk);
    chk({31'h0, done}, {31'h0, r == 1});
    if (r > 1) u_host.send(32'h5a3c_7e12, r - 1);
    u_host.idle();
    wait_flag(1'b0);
    chk({31'h0, done}, 32'h1);
    rchk(OFS_COUNT, 32'h3);
    rchk(OFS_LAST, 32'h5a3c_7e12 & mask);
  endtask
  //////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rchk(OFS_CTRL, 32'h2);
    rchk(OFS_LENGTH, 32'h10);
    bus(1'b1, 8'h14, 32'hffff_ffff);
    rchk(8'h14, 32'h0);
    for (int m = 0; m < 5; m++) begin
      run(MODES[m], RATIOS[m], MASKS[m]);
      wait_flag(1'b1);
      chk({31'h0, user}, 32'h1);
      rchk(OFS_STATUS, 32'h53);
    end
    uclk_run <= 1'b1;
    run(5'h12, 1, 32'hffff_ffff);
    wait_flag(1'b1);
    chk({31'h0, user}, 32'h1);
    uclk_run <= 1'b0;
    bus(1'b1, OFS_CTRL, 32'h2);
    u_host.start();
    u_host.send(32'h1, 1);
    ext_hold_n <= 1'b0;
    repeat (10) @(posedge hclk);
    ext_hold_n <= 1'b1;
    u_host.idle();
    repeat (10) @(posedge hclk);
    bus(1'b0, OFS_STATUS, 32'h0);
    chk(rd & 32'h8, 32'h8);
    bus(1'b1, OFS_STATUS, 32'h8);
    bus(1'b0, OFS_STATUS, 32'h0);
    chk(rd & 32'h8, 32'h0);
    summarize();
  end
endmodule
`default_nettype wire
